// ### hw/fsss_supervisor.sv
`timescale 1ns/100ps
// Contract
// [RULE_01] crank clear resets zero; enable regulator above threshold
// [RULE_02] ramp down: off in reset below threshold
// [RULE_03] crank set: hold regulator until power-on reset
// [RULE_04] safe output low in fail-safe state
// [RULE_05] mode A keeps regulator on until recovery
// [RULE_06] B1 idle 8 s, B2 wake low, B3 both
// [RULE_07] software safe-mode code overrides resistor code
// [RULE_08] latch resistor code on init to normal
// [RULE_09] wake from safe state resumes in reset
// [RULE_10] safe output held until clear command
// [RULE_11] watchdog safe on first or second pulse
// [RULE_12] regulator low: safe with reset same instant
// [RULE_13] externally clamped reset pin enters safe mode
// [RULE_14] 1 ms reset pulse every 256 ms
// [RULE_15] eight consecutive watchdog failures are safe-relevant
// [RULE_16] recovery needs reset, regulator released, refresh
// [RULE_17] bus idle timer restarts on any activity
module fsss_supervisor #(
   parameter int unsigned PULSE_CYC = fsss_pkg::RST_PULSE_CYC,
   parameter int unsigned PERIOD_CYC = fsss_pkg::WD_PERIOD_CYC,
   parameter int unsigned IDLE_CYC = fsss_pkg::BUS_IDLE_CYC
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ce,
   input wire fsss_pkg::fsss_pins_s pins,
   input wire fsss_pkg::fsss_spi_s spi,
   output logic vdd_en,
   output logic rst_o,
   output logic rst_oe_n,
   output logic safe_n,
   output logic battery_loss_flag,
   output logic crank_hold,
   output fsss_pkg::fsss_mode_e mode,
   output fsss_pkg::fsss_code_t safe_mode,
   output fsss_pkg::fsss_flags_s safe_flags
);
   import fsss_pkg::*;

   if (PULSE_CYC < 1 || PERIOD_CYC <= PULSE_CYC || IDLE_CYC < 1) begin : g_chk
      $error("fsss_supervisor: timing parameters out of range");
   end

   // ==========================================================
   // state
   fsss_pins_s s1_r, s;
   fsss_mode_e mode_r, mode_nxt;
   logic [31:0] cnt_r, cnt_nxt, idle_cnt_r, idle_cnt_nxt;
   logic [3:0] fail_cnt_r, fail_cnt_nxt;
   logic [2:0] clamp_cnt_r, clamp_cnt_nxt;
   logic crank_r, safe_second_r, fault_r, fault_nxt, wake_en_r, wake_en_nxt;
   logic ovr_valid_r, vdd_en_r, vdd_en_nxt, rst_oe_n_r, safe_n_r, batt_r, batt_nxt;
   fsss_code_t dbg_code_r, ovr_code_r, safe_mode_r, safe_mode_nxt;
   fsss_flags_s flags_r, flags_nxt;

   // ==========================================================
   // decode
   wire in_rst_st = (mode_r == M_INIT_RST) || (mode_r == M_RESET);
   wire nxt_rst_st = (mode_nxt == M_INIT_RST) || (mode_nxt == M_RESET);
   wire vdd_low = (spi.uv_sel_lo ? s.vdd_below_3v2 : s.vdd_below_4v6) && vdd_en_r;
   wire [31:0] lim = in_rst_st ? PULSE_CYC : PERIOD_CYC;
   wire tmr_done = cnt_r >= (lim - 32'h1);
   wire pulse_done = in_rst_st && tmr_done;
   wire wd_expire = tmr_done && !in_rst_st && (mode_r != M_SAFE_OFF) && !spi.wd_refresh;
   // [RULE_11] first or second
   wire wd_trig = wd_expire && (!safe_second_r || (fail_cnt_r != 4'h0));
   // [RULE_15] eighth consecutive failure
   wire fail8 = wd_expire && (fail_cnt_r == WD_FAIL_MAX - 4'h1);
   // [RULE_13] clamped reset pin
   wire clamp_now = clamp_cnt_r == CLAMP_CYC;
   // [RULE_16] recovery condition
   wire recover = spi.wd_refresh && !clamp_now && !vdd_low && s.rst_pin_in;
   wire cmd_hit = spi.cmd_stb && ((spi.cmd == SAFE_CLR_CMD_A) || (spi.cmd == SAFE_CLR_CMD_B));
   wire io_low = !s.wake_one;
   wire idle_done = idle_cnt_r == IDLE_CYC;
   // [RULE_09] wake sources
   wire wake = s.can_wake || s.lin_wake || (s.wake_one && wake_en_r);
   wire init_to_normal = (mode_r == M_INIT) && (mode_nxt == M_NORMAL);
   logic b_off;

   // [RULE_06] B off conditions
   always_comb begin
      case (safe_mode_r)
         SM_B1: b_off = idle_done;
         SM_B2: b_off = io_low;
         SM_B3: b_off = idle_done && io_low;
         default: b_off = 1'b0;
      endcase
   end

   // ==========================================================
   // mode sequencing
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         // [RULE_14] reset pulse then request
         M_INIT_RST: if (pulse_done && !vdd_low) mode_nxt = M_INIT;
         M_INIT: begin
            if (spi.wd_refresh) mode_nxt = M_NORMAL;
            else if (tmr_done) mode_nxt = M_INIT_RST;
         end
         M_RESET: if (pulse_done && !vdd_low) mode_nxt = M_NORM_REQ;
         M_NORM_REQ: begin
            if (spi.wd_refresh) mode_nxt = M_NORMAL;
            else if (tmr_done) mode_nxt = M_RESET;
         end
         M_NORMAL: if (wd_expire) mode_nxt = M_RESET;
         // [RULE_09] resume in reset
         M_SAFE_OFF: if (wake) mode_nxt = M_RESET;
         default: mode_nxt = M_INIT_RST;
      endcase
      if (mode_r != M_SAFE_OFF) begin
         // [RULE_05] mode A never leaves regulator
         if (fault_r && b_off) begin
            mode_nxt = M_SAFE_OFF;
         end else if (vdd_low) begin
            mode_nxt = ((mode_r == M_INIT_RST) || (mode_r == M_INIT)) ? M_INIT_RST : M_RESET;
         end else if (!vdd_en_r && (mode_r != M_RESET) && (mode_r != M_INIT_RST)) begin
            mode_nxt = M_INIT_RST;
         end
      end
   end

   always_comb begin
      cnt_nxt = cnt_r;
      if (mode_nxt != mode_r || (mode_r == M_NORMAL && spi.wd_refresh)) cnt_nxt = 32'h0;
      else if (!tmr_done) cnt_nxt = cnt_r + 32'h1;
      fail_cnt_nxt = fail_cnt_r;
      if (spi.wd_refresh || mode_r == M_SAFE_OFF) fail_cnt_nxt = 4'h0;
      else if (wd_expire && fail_cnt_r != WD_FAIL_MAX) fail_cnt_nxt = fail_cnt_r + 4'h1;
      clamp_cnt_nxt = 3'h0;
      if (rst_oe_n_r && !s.rst_pin_in) clamp_cnt_nxt = clamp_now ? clamp_cnt_r : clamp_cnt_r + 3'h1;
      // [RULE_16] fault cleared by recovery or wake
      fault_nxt = fault_r;
      if (recover || (mode_r == M_SAFE_OFF && wake)) fault_nxt = 1'b0;
      if (fail8 || clamp_now) fault_nxt = 1'b1;
      wake_en_nxt = (!fault_r && fault_nxt) ? spi.wake_one_en : wake_en_r;
      // [RULE_17] idle restarts on activity
      idle_cnt_nxt = 32'h0;
      if (fault_r && !s.can_active) idle_cnt_nxt = idle_done ? idle_cnt_r : idle_cnt_r + 32'h1;
   end

   // ==========================================================
   // safe flags, regulator enable
   always_comb begin
      // [RULE_10] set wins over clear
      flags_nxt = cmd_hit ? '0 : flags_r;
      if (wd_trig) flags_nxt.wd_fail = 1'b1;
      // [RULE_12] same cycle as reset
      if (vdd_low) flags_nxt.vdd_low = 1'b1;
      if (clamp_now) flags_nxt.rst_clamp = 1'b1;
      // [RULE_07] override over resistor
      safe_mode_nxt = ovr_valid_r ? ovr_code_r : dbg_code_r;
      batt_nxt = s.por_det || (batt_r && !spi.batt_flag_clr);
      if (mode_r == M_SAFE_OFF || mode_nxt == M_SAFE_OFF) begin
         vdd_en_nxt = 1'b0;
      end else if (!vdd_en_r) begin
         // [RULE_01] enable above threshold
         vdd_en_nxt = s.battery_supply_one_ok && !s.por_det;
      end else if (crank_r) begin
         // [RULE_03] hold until power-on reset
         vdd_en_nxt = !s.por_det;
      end else begin
         // [RULE_02] off in reset below threshold
         vdd_en_nxt = !(in_rst_st && vdd_low && !s.battery_supply_one_ok);
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= '0;
         s <= '0;
      end else if (ce) begin
         s1_r <= pins;
         s <= s1_r;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= M_INIT_RST;
         cnt_r <= 32'h0;
         fail_cnt_r <= 4'h0;
         clamp_cnt_r <= 3'h0;
         fault_r <= 1'b0;
         wake_en_r <= 1'b0;
         idle_cnt_r <= 32'h0;
      end else if (ce) begin
         mode_r <= mode_nxt;
         cnt_r <= cnt_nxt;
         fail_cnt_r <= fail_cnt_nxt;
         clamp_cnt_r <= clamp_cnt_nxt;
         fault_r <= fault_nxt;
         wake_en_r <= wake_en_nxt;
         idle_cnt_r <= idle_cnt_nxt;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         crank_r <= CRANK_RST;
         safe_second_r <= SAFE_SECOND_RST;
      end else if (ce && spi.init_wd_wr) begin
         crank_r <= spi.init_wd_data[CRANK_BIT];
         safe_second_r <= spi.init_wd_data[SAFE_SECOND_BIT];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dbg_code_r <= SM_A;
         ovr_valid_r <= 1'b0;
         ovr_code_r <= SM_A;
         safe_mode_r <= SM_A;
      end else if (ce) begin
         // [RULE_08] latch resistor code
         if (init_to_normal) dbg_code_r <= {1'b1, ~s.debug_resistor_pin};
         if (spi.ovr_wr && spi.ovr_code[2]) begin
            ovr_valid_r <= 1'b1;
            ovr_code_r <= spi.ovr_code;
         end
         safe_mode_r <= safe_mode_nxt;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flags_r <= '0;
         safe_n_r <= 1'b1;
         rst_oe_n_r <= 1'b0;
         vdd_en_r <= 1'b0;
         batt_r <= 1'b0;
      end else if (ce) begin
         flags_r <= flags_nxt;
         // [RULE_04] safe low while faulted
         safe_n_r <= !((|flags_nxt) || mode_nxt == M_SAFE_OFF);
         rst_oe_n_r <= !nxt_rst_st;
         vdd_en_r <= vdd_en_nxt;
         batt_r <= batt_nxt;
      end
   end

   assign vdd_en = vdd_en_r;
   assign rst_o = 1'b0;
   assign rst_oe_n = rst_oe_n_r;
   assign safe_n = safe_n_r;
   assign battery_loss_flag = batt_r;
   assign crank_hold = crank_r;
   assign mode = mode_r;
   assign safe_mode = safe_mode_r;
   assign safe_flags = flags_r;

   // ==========================================================
   // assertions
   wire no_off = (mode_r != M_SAFE_OFF) && (mode_nxt != M_SAFE_OFF);

   property p_reg_on;
      @(posedge clock) disable iff (!arst_n)
      ce && !crank_r && !vdd_en_r && s.battery_supply_one_ok && !s.por_det && no_off |=> vdd_en_r;
   endproperty
   a_reg_on: assert property (p_reg_on) else $error("regulator not enabled"); // [RULE_01]

   property p_ramp_off;
      @(posedge clock) disable iff (!arst_n)
      ce && vdd_en_r && !crank_r && in_rst_st && vdd_low && !s.battery_supply_one_ok |=> !vdd_en_r;
   endproperty
   a_ramp_off: assert property (p_ramp_off) else $error("regulator not off on ramp down"); // [RULE_02]

   property p_crank_hold;
      @(posedge clock) disable iff (!arst_n)
      ce && crank_r && s.por_det |=> !vdd_en_r && battery_loss_flag;
   endproperty
   a_crank_hold: assert property (p_crank_hold) else $error("crank hold release wrong"); // [RULE_03]

   property p_safe_low;
      @(posedge clock) disable iff (!arst_n)
      mode_r == M_SAFE_OFF |-> !safe_n_r;
   endproperty
   a_safe_low: assert property (p_safe_low) else $error("safe output high in safe state"); // [RULE_04]

   property p_mode_a;
      @(posedge clock) disable iff (!arst_n)
      ce && safe_mode_r == SM_A && mode_r != M_SAFE_OFF |=> mode_r != M_SAFE_OFF;
   endproperty
   a_mode_a: assert property (p_mode_a) else $error("mode A switched regulator off"); // [RULE_05]

   property p_b2_off;
      @(posedge clock) disable iff (!arst_n)
      ce && fault_r && safe_mode_r == SM_B2 && io_low && mode_r != M_SAFE_OFF |=> mode_r == M_SAFE_OFF ##0 !vdd_en_r;
   endproperty
   a_b2_off: assert property (p_b2_off) else $error("mode B2 did not switch off"); // [RULE_06]

   sequence s_in_safe_wake;
      ce && mode_r == M_SAFE_OFF && wake;
   endsequence
   sequence s_resumed;
      mode_r == M_RESET && !rst_oe_n_r;
   endsequence
   property p_wake_exit;
      @(posedge clock) disable iff (!arst_n)
      s_in_safe_wake |=> s_resumed;
   endproperty
   a_wake_exit: assert property (p_wake_exit) else $error("wake did not resume in reset"); // [RULE_09]

   property p_safe_hold;
      @(posedge clock) disable iff (!arst_n)
      ce && !safe_n_r && !cmd_hit |=> !safe_n_r;
   endproperty
   a_safe_hold: assert property (p_safe_hold) else $error("safe output released without clear"); // [RULE_10]

   property p_wd_first;
      @(posedge clock) disable iff (!arst_n)
      ce && wd_expire && !safe_second_r |=> !safe_n_r && flags_r.wd_fail;
   endproperty
   a_wd_first: assert property (p_wd_first) else $error("watchdog safe not on first pulse"); // [RULE_11]

   property p_vdd_same;
      @(posedge clock) disable iff (!arst_n)
      ce && vdd_low && mode_r != M_SAFE_OFF |=> !safe_n_r && !rst_oe_n_r;
   endproperty
   a_vdd_same: assert property (p_vdd_same) else $error("safe and reset not together"); // [RULE_12]

   property p_pulse_len;
      @(posedge clock) disable iff (!arst_n)
      in_rst_st |-> cnt_r <= PULSE_CYC - 32'h1;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too long"); // [RULE_14]
endmodule // fsss_supervisor

// ### include/fsss_pkg.sv
package fsss_pkg;
   // ==========================================================
   // timing
   localparam longint unsigned CLK_HZ = 125_000_000;
   localparam longint unsigned RST_PULSE_US = 1000;
   localparam longint unsigned WD_PERIOD_MS = 256;
   localparam longint unsigned BUS_IDLE_MS = 8000;
   localparam int unsigned RST_PULSE_CYC = int'((RST_PULSE_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
   localparam int unsigned WD_PERIOD_CYC = int'((WD_PERIOD_MS * CLK_HZ) / 64'd1000);
   localparam int unsigned BUS_IDLE_CYC = int'((BUS_IDLE_MS * CLK_HZ + 64'd999) / 64'd1000);
   localparam logic [3:0] WD_FAIL_MAX = 4'h8;
   localparam logic [2:0] CLAMP_CYC = 3'h4;
   // ==========================================================
   // init watchdog register fields
   localparam int unsigned CRANK_BIT = 0;
   localparam int unsigned SAFE_SECOND_BIT = 4;
   localparam logic CRANK_RST = 1'b0;
   localparam logic SAFE_SECOND_RST = 1'b0;
   // ==========================================================
   // commands and codes
   localparam logic [15:0] SAFE_CLR_CMD_A = 16'h1D80;
   localparam logic [15:0] SAFE_CLR_CMD_B = 16'hDD80;
   typedef logic [2:0] fsss_code_t;
   localparam fsss_code_t SM_A = 3'h7;
   localparam fsss_code_t SM_B1 = 3'h6;
   localparam fsss_code_t SM_B2 = 3'h5;
   localparam fsss_code_t SM_B3 = 3'h4;
   typedef enum logic [2:0] {
      M_INIT_RST, M_INIT, M_RESET, M_NORM_REQ, M_NORMAL, M_SAFE_OFF
   } fsss_mode_e;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic battery_supply_one_ok;
      logic por_det;
      logic vdd_below_4v6;
      logic vdd_below_3v2;
      logic rst_pin_in;
      logic can_active;
      logic can_wake;
      logic lin_wake;
      logic wake_one;
      logic [1:0] debug_resistor_pin;
   } fsss_pins_s;
   typedef struct packed {
      logic init_wd_wr;
      logic [7:0] init_wd_data;
      logic uv_sel_lo;
      logic ovr_wr;
      fsss_code_t ovr_code;
      logic wd_refresh;
      logic cmd_stb;
      logic [15:0] cmd;
      logic wake_one_en;
      logic batt_flag_clr;
   } fsss_spi_s;
   typedef struct packed {
      logic wd_fail;
      logic vdd_low;
      logic rst_clamp;
   } fsss_flags_s;
endpackage

// ### tb/fsss_mcu_model.sv
`timescale 1ns/100ps
// ==========================================================
// microcontroller side: watchdog refresh and reset pin wire
module fsss_mcu_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic refresh_en,
   input wire logic [3:0] gap,
   input wire logic clamp,
   input wire logic rst_o,
   input wire logic rst_oe_n,
   output logic wd_refresh,
   output logic rst_pin
);
   logic [3:0] cnt_r;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 4'h0;
         wd_refresh <= 1'b0;
      end else if (refresh_en && cnt_r >= gap) begin
         cnt_r <= 4'h0;
         wd_refresh <= 1'b1;
      end else begin
         cnt_r <= (cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1;
         wd_refresh <= 1'b0;
      end
   end
   // pin pulled up, clamp holds low
   assign rst_pin = !rst_oe_n ? rst_o : !clamp;
endmodule // fsss_mcu_model

// ### tb/test_fail_safe_supply_supervisor.sv
`timescale 1ns/100ps
module test_fail_safe_supply_supervisor;
   import fsss_pkg::*;
   localparam int unsigned PULSE = 4;
   localparam int unsigned IDLE = 10;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic refresh_en = 1'b0;
   logic clamp = 1'b0;
   logic [3:0] gap = 4'h5;
   logic mdl_refresh, rst_pin, vdd_en, rst_o, rst_oe_n, safe_n, battery_loss_flag, crank_hold;
   fsss_pins_s pins_r = '0;
   fsss_spi_s spi_r = '0;
   fsss_pins_s pins;
   fsss_spi_s spi;
   fsss_mode_e mode;
   fsss_code_t safe_mode;
   fsss_flags_s safe_flags;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   int w, i, j, n;
   logic [1:0] res_code;
   always_comb begin
      pins = pins_r;
      pins.rst_pin_in = rst_pin;
      spi = spi_r;
      spi.wd_refresh = spi_r.wd_refresh | mdl_refresh;
   end
   fsss_supervisor #(.PULSE_CYC(PULSE), .PERIOD_CYC(20), .IDLE_CYC(IDLE)) fsss_supervisor_inst (
      .clock(clock), .arst_n(arst_n), .ce(ce), .pins(pins), .spi(spi), .vdd_en(vdd_en), .rst_o(rst_o),
      .rst_oe_n(rst_oe_n), .safe_n(safe_n), .battery_loss_flag(battery_loss_flag), .crank_hold(crank_hold),
      .mode(mode), .safe_mode(safe_mode), .safe_flags(safe_flags));
   fsss_mcu_model fsss_mcu_model_inst (
      .clock(clock), .arst_n(arst_n), .refresh_en(refresh_en), .gap(gap), .clamp(clamp), .rst_o(rst_o),
      .rst_oe_n(rst_oe_n), .wd_refresh(mdl_refresh), .rst_pin(rst_pin));
   initial begin
      forever #4 clock = ~clock;
   end
   // ==========================================================
   // helpers
   function automatic fsss_code_t res_map(input logic [1:0] r);
      return fsss_code_t'(3'h7 - {1'b0, r});
   endfunction
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task automatic wait_mode(input fsss_mode_e m, input int lim);
      for (int k = 0; k < lim && mode !== m; k++) @(negedge clock);
      chk("mode", 16'(m), 16'(mode));
   endtask
   task automatic wait_safe(input logic v, input int lim);
      for (int k = 0; k < lim && safe_n !== v; k++) @(negedge clock);
   endtask
   task automatic spi_op(input int kind, input logic [15:0] d);
      @(posedge clock);
      spi_r.cmd <= d;
      spi_r.init_wd_data <= d[7:0];
      spi_r.ovr_code <= d[2:0];
      spi_r.cmd_stb <= (kind == 0);
      spi_r.init_wd_wr <= (kind == 1);
      spi_r.ovr_wr <= (kind == 2);
      @(posedge clock);
      spi_r.cmd_stb <= 1'b0;
      spi_r.init_wd_wr <= 1'b0;
      spi_r.ovr_wr <= 1'b0;
      repeat (2) @(negedge clock);
   endtask
   task automatic pulse(output int wdt);
      wdt = 0;
      for (int k = 0; k < 60 && rst_oe_n !== 1'b0; k++) @(negedge clock);
      while (rst_oe_n === 1'b0 && wdt < 60) begin
         wdt++;
         @(negedge clock);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         summarize();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'h639c491d));
      res_code = 2'($urandom_range(3, 0));
      @(posedge clock);
      pins_r.debug_resistor_pin <= res_code;
      gap <= 4'($urandom_range(12, 3));
      repeat (8) @(posedge clock);
      chk("vdd_en in reset", 0, vdd_en);
      chk("crank in reset", 0, crank_hold);
      chk("safe_n in reset", 1, safe_n);
      @(posedge clock);
      arst_n <= 1'b1;
      pins_r.battery_supply_one_ok <= 1'b1;
      refresh_en <= 1'b1;
      for (int k = 0; k < 6 && vdd_en !== 1'b1; k++) @(negedge clock);
      chk("vdd_en after supply", 1, vdd_en);
      wait_mode(M_NORMAL, 200);
      // effective code follows the latched one a cycle later
      @(negedge clock);
      chk("latched code", 16'(res_map(res_code)), 16'(safe_mode));
      spi_op(0, SAFE_CLR_CMD_A);
      $display("test power_up done");
      for (i = 0; i < 2; i++) begin
         spi_op(1, (i == 1) ? 16'h0010 : 16'h0000);
         @(posedge clock);
         refresh_en <= 1'b0;
         for (j = 0; j <= i; j++) begin
            pulse(w);
            chk("pulse width", 16'(PULSE), 16'(w));
            chk("safe_n after pulse", (j == i) ? 0 : 1, safe_n);
         end
         chk("wd flag", 1, safe_flags.wd_fail);
         @(posedge clock);
         refresh_en <= 1'b1;
         wait_mode(M_NORMAL, 100);
         spi_op(0, 16'h1D81);
         chk("safe_n bad clear", 0, safe_n);
         spi_op(0, i ? SAFE_CLR_CMD_B : SAFE_CLR_CMD_A);
         chk("safe_n cleared", 1, safe_n);
      end
      $display("test watchdog done");
      for (i = 7; i >= 3; i--) begin
         spi_op(2, 16'(i));
         chk("override", (i == 3) ? 16'(SM_B3) : 16'(i), 16'(safe_mode));
      end
      spi_op(2, 16'(SM_A));
      @(posedge clock);
      ce <= 1'b0;
      spi_op(2, 16'(SM_B1));
      chk("override while frozen", 16'(SM_A), 16'(safe_mode));
      @(posedge clock);
      ce <= 1'b1;
      $display("test override done");
      @(posedge clock);
      pins_r.vdd_below_4v6 <= 1'b1;
      wait_safe(1'b0, 10);
      chk("reset with safe", 0, rst_oe_n);
      chk("vdd kept in A", 1, vdd_en);
      @(posedge clock);
      pins_r.vdd_below_4v6 <= 1'b0;
      wait_mode(M_NORMAL, 200);
      spi_op(0, SAFE_CLR_CMD_A);
      chk("recovered", 1, safe_n);
      $display("test vdd_low done");
      spi_op(2, 16'(SM_B1));
      @(posedge clock);
      clamp <= 1'b1;
      wait_safe(1'b0, 20);
      chk("clamp flag", 1, safe_flags.rst_clamp);
      for (j = 0; j < 6; j++) begin
         @(posedge clock);
         pins_r.can_active <= 1'b1;
         @(posedge clock);
         pins_r.can_active <= 1'b0;
         repeat ($urandom_range(7, 2)) @(negedge clock);
         chk("no idle expiry", 1, mode !== M_SAFE_OFF);
      end
      // last activity at a known edge, idle time counted from it
      @(posedge clock);
      pins_r.can_active <= 1'b1;
      @(posedge clock);
      pins_r.can_active <= 1'b0;
      for (n = 0; n < 30 && vdd_en !== 1'b0; n++) @(negedge clock);
      chk("idle time", 1, n >= IDLE && n <= IDLE + 5);
      chk("mode off", 16'(M_SAFE_OFF), 16'(mode));
      @(posedge clock);
      clamp <= 1'b0;
      // let the clamp filter drain before the wake event
      repeat (4) @(posedge clock);
      pins_r.can_wake <= 1'b1;
      wait_mode(M_RESET, 8);
      @(posedge clock);
      pins_r.can_wake <= 1'b0;
      $display("test safe_b1 done");
      wait_mode(M_NORMAL, 200);
      spi_op(2, 16'(SM_B2));
      @(posedge clock);
      refresh_en <= 1'b0;
      for (j = 0; j < 8; j++) begin
         pulse(w);
         chk("mode after failures", (j == 7) ? 16'(M_SAFE_OFF) : 16'(M_NORM_REQ), 16'(mode));
      end
      chk("vdd off in B2", 0, vdd_en);
      @(posedge clock);
      pins_r.wake_one <= 1'b1;
      repeat (6) @(negedge clock);
      chk("wake one not enabled", 16'(M_SAFE_OFF), 16'(mode));
      @(posedge clock);
      pins_r.lin_wake <= 1'b1;
      refresh_en <= 1'b1;
      wait_mode(M_RESET, 8);
      @(posedge clock);
      pins_r.lin_wake <= 1'b0;
      pins_r.wake_one <= 1'b0;
      wait_mode(M_NORMAL, 200);
      $display("test safe_b2 done");
      spi_op(1, 16'h0001);
      chk("crank bit", 1, crank_hold);
      @(posedge clock);
      pins_r.battery_supply_one_ok <= 1'b0;
      repeat (20) @(negedge clock);
      chk("vdd held", 1, vdd_en);
      @(posedge clock);
      pins_r.por_det <= 1'b1;
      for (int k = 0; k < 10 && vdd_en !== 1'b0; k++) @(negedge clock);
      chk("vdd off at por", 0, vdd_en);
      chk("battery flag", 1, battery_loss_flag);
      $display("test crank done");
      summarize();
   end
endmodule // test_fail_safe_supply_supervisor
